// >>> pkg/isc_defs.svh
`ifndef ISC_DEFS_SVH
`define ISC_DEFS_SVH

// register word addresses on the plain register port
`define ISC_ADDR_RELOAD 8'h00
`define ISC_ADDR_BUFFER 8'h04
`define ISC_ADDR_CTRL2 8'h08
`define ISC_ADDR_FLAGS 8'h0c
`define ISC_ADDR_MASK 8'h10
`define ISC_ADDR_LINES 8'h14

// serial_control_two bit positions
`define ISC_CTL_START 0
`define ISC_CTL_RESTART 1
`define ISC_CTL_STOP 2
`define ISC_CTL_ACK 3
`define ISC_CTL_ACKDT 5
`define ISC_CTL_EN_MASK 8'h0f

// flag and mask bit positions
`define ISC_FLG_COLL 0
`define ISC_FLG_EVT 1

// line status bit positions
`define ISC_LN_SDA 0
`define ISC_LN_SCL 1
`define ISC_LN_BUSY 2

// reset values
`define ISC_RELOAD_RST 8'h13
`define ISC_BYTE_ZERO 8'h00

// instruction cycle period and system clock period, in ns
`define ISC_INSTR_NS 500
`define ISC_SYS_NS 8
`define ISC_INSTR_DIV (`ISC_INSTR_NS / `ISC_SYS_NS)

`endif

// >>> pkg/isc_pkg.sv
package isc_pkg;

  typedef struct packed {
    logic scl;
    logic sda;
  } isc_line_t;

  typedef enum logic [4:0] {
    ST_IDLE,
    ST_ST_CNT1,
    ST_ST_CNT2,
    ST_RS_SDA,
    ST_RS_CNT1,
    ST_RS_SCLH,
    ST_RS_CNT2,
    ST_RS_CNT3,
    ST_SP_SDAL,
    ST_SP_SCLH,
    ST_SP_CNT1,
    ST_SP_CNT2,
    ST_AK_CNT1,
    ST_AK_SCLH,
    ST_AK_CNT2,
    ST_BUF_CNT
  } isc_state_t;

endpackage : isc_pkg

// >>> hw/isc_master_core.sv
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "isc_defs.svh"

module isc_master_core #(
  parameter int INSTR_DIV = `ISC_INSTR_DIV
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // open-drain bus lines
  input wire isc_pkg::isc_line_t line_in,
  output isc_pkg::isc_line_t line_out,
  output isc_pkg::isc_line_t line_oe_out,
  // interrupt
  output logic irq_out
);

  // line synchronisers: a level counts once stages two and three agree
  isc_pkg::isc_line_t sync1_q, sync2_q, sync3_q, filt_q;
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_q <= '1;
      sync2_q <= '1;
      sync3_q <= '1;
      filt_q <= '1;
    end else begin
      sync1_q <= line_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      if (sync2_q.scl == sync3_q.scl) filt_q.scl <= sync3_q.scl;
      if (sync2_q.sda == sync3_q.sda) filt_q.sda <= sync3_q.sda;
    end
  end
  wire logic scl_f = filt_q.scl;
  wire logic sda_f = filt_q.sda;

  // instruction cycle tick
  logic [15:0] div_q;
  wire logic tick = (div_q == 16'(INSTR_DIV - 1));
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) div_q <= '0;
    else if (tick) div_q <= '0;
    else div_q <= div_q + 16'h0001;
  end

  // registers
  logic [7:0] reload_q, buffer_q, ctrl_q, flags_q, mask_q;
  isc_pkg::isc_state_t state_q, state_d;
  logic sda_drv_q, sda_drv_d, scl_drv_q, scl_drv_d;
  logic [7:0] cnt_q;
  logic load, coll, done;

  wire logic idle = (state_q == isc_pkg::ST_IDLE);
  wire logic wr_reload = reg_wr_in && (reg_addr_in == `ISC_ADDR_RELOAD);
  wire logic wr_buffer = reg_wr_in && (reg_addr_in == `ISC_ADDR_BUFFER);
  wire logic wr_ctrl = reg_wr_in && (reg_addr_in == `ISC_ADDR_CTRL2);
  wire logic wr_flags = reg_wr_in && (reg_addr_in == `ISC_ADDR_FLAGS);
  wire logic wr_mask = reg_wr_in && (reg_addr_in == `ISC_ADDR_MASK);

  wire logic run = !idle && (state_q != isc_pkg::ST_RS_SDA) &&
                   (state_q != isc_pkg::ST_RS_SCLH) && (state_q != isc_pkg::ST_SP_SDAL) &&
                   (state_q != isc_pkg::ST_SP_SCLH) && (state_q != isc_pkg::ST_AK_SCLH);
  wire logic expire = run && tick && (cnt_q == `ISC_BYTE_ZERO);

  wire logic go_start = idle && ctrl_q[`ISC_CTL_START];
  wire logic go_restart = idle && ctrl_q[`ISC_CTL_RESTART];
  wire logic go_stop = idle && ctrl_q[`ISC_CTL_STOP];
  wire logic go_ack = idle && ctrl_q[`ISC_CTL_ACK];

  // sequence control
  always_comb begin
    state_d = state_q;
    sda_drv_d = sda_drv_q;
    scl_drv_d = scl_drv_q;
    load = 1'b0;
    coll = 1'b0;
    done = 1'b0;
    case (state_q)
      isc_pkg::ST_IDLE: begin
        if (go_start) begin
          load = 1'b1;
          state_d = isc_pkg::ST_ST_CNT1;
        end else if (go_restart) begin
          sda_drv_d = 1'b0;
          state_d = isc_pkg::ST_RS_SDA;
        end else if (go_stop) begin
          sda_drv_d = 1'b1;
          state_d = isc_pkg::ST_SP_SDAL;
        end else if (go_ack) begin
          scl_drv_d = 1'b1;
          sda_drv_d = !ctrl_q[`ISC_CTL_ACKDT];
          load = 1'b1;
          state_d = isc_pkg::ST_AK_CNT1;
        end else if (wr_buffer) begin
          load = 1'b1;
          state_d = isc_pkg::ST_BUF_CNT;
        end
      end
      isc_pkg::ST_ST_CNT1: begin
        if (expire) begin
          sda_drv_d = 1'b1;
          load = 1'b1;
          state_d = isc_pkg::ST_ST_CNT2;
        end
      end
      isc_pkg::ST_ST_CNT2: begin
        if (expire) begin
          scl_drv_d = 1'b1;
          done = 1'b1;
        end
      end
      isc_pkg::ST_RS_SDA: begin
        if (sda_f) begin
          load = 1'b1;
          state_d = isc_pkg::ST_RS_CNT1;
        end
      end
      isc_pkg::ST_RS_CNT1: begin
        if (expire) begin
          scl_drv_d = 1'b0;
          state_d = isc_pkg::ST_RS_SCLH;
        end
      end
      isc_pkg::ST_RS_SCLH: begin
        if (scl_f && !sda_f) begin
          coll = 1'b1;
        end else if (scl_f) begin
          load = 1'b1;
          state_d = isc_pkg::ST_RS_CNT2;
        end
      end
      isc_pkg::ST_RS_CNT2: begin
        // another master pulling data low here is ignored
        if (!scl_f && !sda_drv_q) begin
          coll = 1'b1;
        end else if (expire) begin
          sda_drv_d = 1'b1;
          load = 1'b1;
          state_d = isc_pkg::ST_RS_CNT3;
        end
      end
      isc_pkg::ST_RS_CNT3: begin
        if (expire) begin
          scl_drv_d = 1'b1;
          done = 1'b1;
        end
      end
      isc_pkg::ST_SP_SDAL: begin
        if (!sda_f) begin
          scl_drv_d = 1'b0;
          state_d = isc_pkg::ST_SP_SCLH;
        end
      end
      isc_pkg::ST_SP_SCLH: begin
        if (scl_f) begin
          load = 1'b1;
          state_d = isc_pkg::ST_SP_CNT1;
        end
      end
      isc_pkg::ST_SP_CNT1: begin
        if (!scl_f) begin
          coll = 1'b1;
        end else if (expire) begin
          sda_drv_d = 1'b0;
          load = 1'b1;
          state_d = isc_pkg::ST_SP_CNT2;
        end
      end
      isc_pkg::ST_SP_CNT2: begin
        if (!scl_f && !sda_f) begin
          coll = 1'b1;
        end else if (expire && !sda_f) begin
          coll = 1'b1;
        end else if (expire) begin
          done = 1'b1;
        end
      end
      isc_pkg::ST_AK_CNT1: begin
        if (expire) begin
          scl_drv_d = 1'b0;
          state_d = isc_pkg::ST_AK_SCLH;
        end
      end
      isc_pkg::ST_AK_SCLH: begin
        if (scl_f) begin
          load = 1'b1;
          state_d = isc_pkg::ST_AK_CNT2;
        end
      end
      isc_pkg::ST_AK_CNT2: begin
        if (expire) begin
          scl_drv_d = 1'b1;
          sda_drv_d = 1'b0;
          done = 1'b1;
        end
      end
      isc_pkg::ST_BUF_CNT: begin
        if (expire) done = 1'b1;
      end
      default: state_d = isc_pkg::ST_IDLE;
    endcase
    if (coll) begin
      sda_drv_d = 1'b0;
      scl_drv_d = 1'b0;
      state_d = isc_pkg::ST_IDLE;
    end else if (done) begin
      state_d = isc_pkg::ST_IDLE;
    end
  end

  // enable bits: software sets only while idle, hardware clears on end or abort
  wire logic [7:0] ctrl_en_mask = `ISC_CTL_EN_MASK;
  logic [7:0] ctrl_d;
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl && idle) ctrl_d = reg_wdata_in;
    else if (wr_ctrl) ctrl_d = (reg_wdata_in & ~ctrl_en_mask) | (ctrl_q & ctrl_en_mask);
    if (coll || done) ctrl_d = ctrl_d & ~ctrl_en_mask;
  end

  // sticky flags, write one to clear, hardware set wins
  wire logic [7:0] flag_set = {6'h00, done, coll};
  wire logic [7:0] flag_clr = wr_flags ? reg_wdata_in : `ISC_BYTE_ZERO;
  wire logic [7:0] flags_d = (flags_q & ~flag_clr) | flag_set;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= isc_pkg::ST_IDLE;
      sda_drv_q <= 1'b0;
      scl_drv_q <= 1'b0;
      ctrl_q <= `ISC_BYTE_ZERO;
      flags_q <= `ISC_BYTE_ZERO;
    end else begin
      state_q <= state_d;
      sda_drv_q <= sda_drv_d;
      scl_drv_q <= scl_drv_d;
      ctrl_q <= ctrl_d;
      flags_q <= flags_d;
    end
  end

  // writes to a buffer while busy are dropped
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reload_q <= `ISC_RELOAD_RST;
      buffer_q <= `ISC_BYTE_ZERO;
      mask_q <= `ISC_BYTE_ZERO;
    end else begin
      if (wr_reload) reload_q <= reg_wdata_in;
      if (wr_buffer && idle) buffer_q <= reg_wdata_in;
      if (wr_mask) mask_q <= reg_wdata_in;
    end
  end

  // rate counter: reload+1 instruction cycles per phase, two phases per period
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) cnt_q <= `ISC_BYTE_ZERO;
    else if (load) cnt_q <= reload_q;
    else if (run && tick && cnt_q != `ISC_BYTE_ZERO) cnt_q <= cnt_q - 8'h01;
  end

  // read path, data one cycle after the strobe
  wire logic [7:0] lines_rd = {5'h00, !idle, scl_f, sda_f};
  wire logic [7:0] rd_mux =
    (reg_addr_in == `ISC_ADDR_RELOAD) ? reload_q :
    (reg_addr_in == `ISC_ADDR_BUFFER) ? buffer_q :
    (reg_addr_in == `ISC_ADDR_CTRL2) ? ctrl_q :
    (reg_addr_in == `ISC_ADDR_FLAGS) ? flags_q :
    (reg_addr_in == `ISC_ADDR_MASK) ? mask_q :
    (reg_addr_in == `ISC_ADDR_LINES) ? lines_rd : `ISC_BYTE_ZERO;
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) reg_rdata_out <= `ISC_BYTE_ZERO;
    else if (reg_rd_in) reg_rdata_out <= rd_mux;
    else reg_rdata_out <= `ISC_BYTE_ZERO;
  end

  assign line_out = '0;
  assign line_oe_out.scl = scl_drv_q;
  assign line_oe_out.sda = sda_drv_q;
  assign irq_out = |(flags_q & mask_q);

  // checks
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  rs_sda_low_a: assert property (
    state_q == isc_pkg::ST_RS_SCLH && scl_f && !sda_f |=>
      flags_q[`ISC_FLG_COLL] && idle && !scl_drv_q && !sda_drv_q)
    else $error("repeated start data low not flagged");

  rs_scl_fall_a: assert property (
    state_q == isc_pkg::ST_RS_CNT2 && !scl_f && !sda_drv_q |=>
      flags_q[`ISC_FLG_COLL] && idle)
    else $error("repeated start clock fall not flagged");

  rs_load_a: assert property (
    state_q == isc_pkg::ST_RS_SDA && sda_f |=>
      cnt_q == $past(reload_q) && state_q == isc_pkg::ST_RS_CNT1)
    else $error("repeated start counter not loaded");

  rs_drive_sda_a: assert property (
    state_q == isc_pkg::ST_RS_CNT2 && expire && scl_f |=>
      sda_drv_q && state_q == isc_pkg::ST_RS_CNT3 && cnt_q == $past(reload_q))
    else $error("repeated start data not driven low");

  rs_end_scl_a: assert property (
    state_q == isc_pkg::ST_RS_CNT3 && expire |=>
      scl_drv_q && idle && !ctrl_q[`ISC_CTL_RESTART] && flags_q[`ISC_FLG_EVT])
    else $error("repeated start did not end with clock low");

  sp_release_a: assert property (
    state_q == isc_pkg::ST_SP_SDAL && !sda_f |=> !scl_drv_q && sda_drv_q)
    else $error("stop did not release clock");

  sp_load_a: assert property (
    state_q == isc_pkg::ST_SP_SCLH && !scl_f |=> state_q == isc_pkg::ST_SP_SCLH)
    else $error("stop counter started before clock high");

  sp_late_sda_a: assert property (
    state_q == isc_pkg::ST_SP_CNT2 && expire && !sda_f |=> flags_q[`ISC_FLG_COLL])
    else $error("stop data low after expiry not flagged");

  coll_abort_a: assert property (
    coll |=> !sda_drv_q && !scl_drv_q && (ctrl_q & ctrl_en_mask) == `ISC_BYTE_ZERO)
    else $error("collision did not abort sequence");

  cnt_step_a: assert property (
    run && tick && !load && cnt_q != `ISC_BYTE_ZERO |=> cnt_q == $past(cnt_q) - 8'h01)
    else $error("rate counter did not step");

  rs_late_sda_a: assert property (
    state_q == isc_pkg::ST_RS_CNT2 && scl_f && !sda_f && !expire |=>
      state_q == isc_pkg::ST_RS_CNT2 && !sda_drv_q)
    else $error("repeated start data fall taken as collision");

  sp_scl_low_a: assert property (
    state_q == isc_pkg::ST_SP_CNT1 && !scl_f |=>
      flags_q[`ISC_FLG_COLL] && idle && !scl_drv_q && !sda_drv_q)
    else $error("stop clock low not flagged");

  buf_start_a: assert property (
    idle && wr_buffer && (ctrl_q & ctrl_en_mask) == `ISC_BYTE_ZERO |=>
      state_q == isc_pkg::ST_BUF_CNT && cnt_q == $past(reload_q))
    else $error("buffer write did not start the counter");

  idle_hold_a: assert property (
    idle && !go_start && !go_ack && !wr_buffer |=>
      scl_drv_q == $past(scl_drv_q) && cnt_q == $past(cnt_q))
    else $error("counter or clock moved while idle");

endmodule : isc_master_core

// >>> testbench/isc_far_end.sv
`timescale 1ns/1ps

module isc_far_end (
  // clocks
  input wire logic clk_link_in,
  // pull requests from the bench
  input wire logic hold_scl_in,
  input wire logic hold_sda_in,
  // open-drain lines
  input wire isc_pkg::isc_line_t oe_in,
  output isc_pkg::isc_line_t line_out
);
  logic hold_scl_q = 1'b0;
  logic hold_sda_q = 1'b0;

  // the other master acts on its own clock, so pulls land out of phase
  always @(posedge clk_link_in) begin
    hold_scl_q <= hold_scl_in;
    hold_sda_q <= hold_sda_in;
  end

  // wired-and with pull-ups; fastest reload only used where it is needed
  assign line_out.scl = !(oe_in.scl | hold_scl_q);
  assign line_out.sda = !(oe_in.sda | hold_sda_q);
endmodule : isc_far_end

// >>> testbench/testbench.sv
`timescale 1ns/1ps
`include "isc_defs.svh"

module testbench;
  localparam int DIV = 2;
  logic clk_sys_in = 1'b0;
  logic clk_link = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [7:0] reg_rdata_out;
  logic irq_out;
  logic hold_scl = 1'b0;
  logic hold_sda = 1'b0;
  isc_pkg::isc_line_t line;
  isc_pkg::isc_line_t line_out;
  isc_pkg::isc_line_t line_oe_out;
  int failures = 0;
  int n_tests = 0;
  int n;

  always #4 clk_sys_in = ~clk_sys_in;
  initial begin
    #3;
    forever #32 clk_link = ~clk_link;
  end

  isc_master_core #(.INSTR_DIV(DIV)) isc_master_core_inst (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .line_in(line), .line_out(line_out),
    .line_oe_out(line_oe_out), .irq_out(irq_out));

  isc_far_end isc_far_end_inst (.clk_link_in(clk_link), .hold_scl_in(hold_scl),
    .hold_sda_in(hold_sda), .oe_in(line_oe_out), .line_out(line));

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic win(input string what, input int v, input int lo, input int hi);
    check(what, {7'h00, (v >= lo && v <= hi)}, 8'h01);
  endtask : win

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask : wr

  task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    @(negedge clk_sys_in);
    check(what, reg_rdata_out, exp);
  endtask : rdc

  function automatic logic probe(input int k);
    return (k == 0) ? irq_out : (k == 1) ? line_oe_out.sda : line_oe_out.scl;
  endfunction : probe

  task automatic wait_for(input int k, input logic v, output int cnt);
    cnt = 0;
    @(negedge clk_sys_in);
    while (probe(k) !== v) begin
      @(negedge clk_sys_in);
      cnt++;
      if (cnt > 3000) begin
        check("wait bound", 8'h00, 8'h01);
        final_report();
      end
    end
  endtask : wait_for

  task automatic t_regs();
    rdc("reload reset", `ISC_ADDR_RELOAD, `ISC_RELOAD_RST);
    rdc("flags reset", `ISC_ADDR_FLAGS, 8'h00);
    rdc("ctrl reset", `ISC_ADDR_CTRL2, 8'h00);
    rdc("lines idle", `ISC_ADDR_LINES, 8'h03);
    wr(8'h20, 8'hff);
    rdc("unmapped", 8'h20, 8'h00);
    wr(`ISC_ADDR_MASK, 8'h03);
    rdc("mask", `ISC_ADDR_MASK, 8'h03);
    check("idle oe", {6'h00, line_oe_out}, 8'h00);
    $display("test regs done");
  endtask : t_regs

  // restart then stop at each table reload value, timing the last restart phase and both stop phases together
  task automatic t_rates();
    logic [7:0] rl [3] = '{8'h04, 8'h0b, 8'h13};
    for (int i = 0; i < 3; i++) begin
      wr(`ISC_ADDR_RELOAD, rl[i]);
      wr(`ISC_ADDR_CTRL2, 8'h02);
      wait_for(1, 1'b1, n);
      wait_for(0, 1'b1, n);
      win("restart phase", n, rl[i] * DIV, (rl[i] + 1) * DIV + 3);
      check("restart oe", {6'h00, line_oe_out}, 8'h03);
      rdc("restart flags", `ISC_ADDR_FLAGS, 8'h02);
      rdc("restart ctrl", `ISC_ADDR_CTRL2, 8'h00);
      wr(`ISC_ADDR_FLAGS, 8'h03);
      repeat (20) @(negedge clk_sys_in);
      check("oe held", {6'h00, line_oe_out}, 8'h03);
      wr(`ISC_ADDR_CTRL2, 8'h04);
      wait_for(2, 1'b0, n);
      wait_for(0, 1'b1, n);
      win("stop time", n, 2 * rl[i] * DIV, 2 * (rl[i] + 1) * DIV + 8);
      rdc("stop flags", `ISC_ADDR_FLAGS, 8'h02);
      check("stop oe", {6'h00, line_oe_out}, 8'h00);
      wr(`ISC_ADDR_FLAGS, 8'h03);
    end
    $display("test rates done");
  endtask : t_rates

  // another master pulls a line part way through a restart or stop
  task automatic t_cond(input logic [7:0] ctl, input logic on_scl, input int dly,
                        input logic [7:0] exp);
    wr(`ISC_ADDR_CTRL2, ctl);
    repeat (dly) @(posedge clk_sys_in);
    if (on_scl) hold_scl <= 1'b1;
    else hold_sda <= 1'b1;
    wait_for(0, 1'b1, n);
    rdc("cond flags", `ISC_ADDR_FLAGS, exp);
    rdc("cond ctrl", `ISC_ADDR_CTRL2, 8'h00);
    check("cond oe", {6'h00, line_oe_out}, exp[0] ? 8'h00 : 8'h03);
    @(posedge clk_sys_in);
    hold_scl <= 1'b0;
    hold_sda <= 1'b0;
    repeat (16) @(posedge clk_sys_in);
    wr(`ISC_ADDR_FLAGS, 8'h03);
    wr(`ISC_ADDR_CTRL2, 8'h04);
    wait_for(0, 1'b1, n);
    wr(`ISC_ADDR_FLAGS, 8'h03);
    $display("test cond done");
  endtask : t_cond

  // a slow device stretches the clock before the stop count may start
  task automatic t_stretch();
    hold_scl <= 1'b1;
    repeat (16) @(posedge clk_sys_in);
    wr(`ISC_ADDR_CTRL2, 8'h04);
    repeat (60) @(negedge clk_sys_in);
    check("stretch irq", {7'h00, irq_out}, 8'h00);
    check("stretch oe", {6'h00, line_oe_out}, 8'h01);
    rdc("stretch lines", `ISC_ADDR_LINES, 8'h04);
    wr(`ISC_ADDR_BUFFER, 8'h3c);
    rdc("busy buffer", `ISC_ADDR_BUFFER, 8'h00);
    @(posedge clk_sys_in);
    hold_scl <= 1'b0;
    wait_for(0, 1'b1, n);
    win("stretch time", n, 2 * 8'h13 * DIV, 2 * 8'h14 * DIV + 16);
    rdc("stretch flags", `ISC_ADDR_FLAGS, 8'h02);
    wr(`ISC_ADDR_FLAGS, 8'h03);
    $display("test stretch done");
  endtask : t_stretch

  task automatic t_buf();
    wr(`ISC_ADDR_RELOAD, 8'h04);
    wr(`ISC_ADDR_BUFFER, 8'ha5);
    wait_for(0, 1'b1, n);
    win("buffer count", n, 4 * DIV, 5 * DIV + 4);
    rdc("buffer flags", `ISC_ADDR_FLAGS, 8'h02);
    rdc("buffer data", `ISC_ADDR_BUFFER, 8'ha5);
    check("buffer oe", {6'h00, line_oe_out}, 8'h00);
    wr(`ISC_ADDR_MASK, 8'h01);
    @(negedge clk_sys_in);
    check("masked irq", {7'h00, irq_out}, 8'h00);
    wr(`ISC_ADDR_MASK, 8'h03);
    @(negedge clk_sys_in);
    check("unmasked irq", {7'h00, irq_out}, 8'h01);
    wr(`ISC_ADDR_FLAGS, 8'h02);
    @(negedge clk_sys_in);
    check("cleared irq", {7'h00, irq_out}, 8'h00);
    $display("test buffer done");
  endtask : t_buf

  // start then acknowledge, each ended by the counter, then a stop frees the bus
  task automatic t_seq();
    wr(`ISC_ADDR_CTRL2, 8'h01);
    wait_for(0, 1'b1, n);
    win("start time", n, 2 * 4 * DIV, 2 * 5 * DIV + 4);
    check("start oe", {6'h00, line_oe_out}, 8'h03);
    wr(`ISC_ADDR_FLAGS, 8'h03);
    wr(`ISC_ADDR_CTRL2, 8'h08);
    wait_for(2, 1'b0, n);
    check("ack oe", {6'h00, line_oe_out}, 8'h01);
    wait_for(0, 1'b1, n);
    check("ack end oe", {6'h00, line_oe_out}, 8'h02);
    rdc("ack ctrl", `ISC_ADDR_CTRL2, 8'h00);
    wr(`ISC_ADDR_FLAGS, 8'h03);
    wr(`ISC_ADDR_CTRL2, 8'h04);
    wait_for(0, 1'b1, n);
    rdc("seq stop flags", `ISC_ADDR_FLAGS, 8'h02);
    wr(`ISC_ADDR_FLAGS, 8'h03);
    $display("test seq done");
  endtask : t_seq

  initial begin
    repeat (20) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    t_regs();
    t_rates();
    t_cond(8'h02, 1'b0, 20, 8'h01);
    t_cond(8'h02, 1'b1, 65, 8'h01);
    t_cond(8'h02, 1'b0, 65, 8'h02);
    t_cond(8'h04, 1'b0, 0, 8'h01);
    t_cond(8'h04, 1'b1, 20, 8'h01);
    t_stretch();
    t_buf();
    t_seq();
    final_report();
  end
endmodule : testbench
